/* File: reset_pin_pkg.sv */
/*
  shared constants and carrier types for the reset pin controller.
  assumes a 100 MHz system clock; no bus, no registers.
*/
package reset_pin_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SYNC_STAGES = 2;
  localparam int unsigned DRIVE_CYCLES = 6;
  localparam int unsigned DRIVE_CNT_W = 3;

  localparam logic [DRIVE_CNT_W-1:0] DRIVE_CNT_RST = 3'h0;

  typedef enum logic [1:0] {
    ST_POWER_HOLD,
    ST_RUN,
    ST_SENSE,
    ST_DRIVE
  } seq_state_t;

  // reset requests handed to the rest of the chip, all active high
  typedef struct packed {
    logic por_domain;
    logic core_domain;
    logic run_allowed;
  } reset_req_t;

  // soft reset pad as two signals
  typedef struct packed {
    logic out_val;
    logic out_en;
  } pad_drive_t;

endpackage

/* File: reset_sync.sv */
/*
  two-or-more stage level synchroniser.
  assumes the input is asynchronous to clk; output is a plain level.
*/
`timescale 1ns/100ps

module reset_sync #(
  parameter int unsigned STAGES = reset_pin_pkg::SYNC_STAGES,
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic din,
  output logic dout
);

  logic [STAGES-1:0] chain_q;
  logic [STAGES-1:0] chain_d;

  if (STAGES < 2) begin : g_bad_stages
    $error("reset_sync needs at least two stages");
  end

  // first stage is read only by the second
  always_comb begin
    chain_d = {chain_q[STAGES-2:0], din};
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      chain_q <= {STAGES{RESET_VAL}};
    end else begin
      chain_q <= chain_d;
    end
  end

  assign dout = chain_q[STAGES-1];

endmodule

/* File: reset_pin_controller.sv */
/*
  reset pin controller: power reset input and two-way soft reset pin,
  producing reset requests for the por and core domains.
  assumes one 100 MHz clock and that rst_b is a raw power-good reset;
  the rtc, debug engine and scan debugger take neither request.
*/
// Operation
// RULE1: power reset input low keeps the device held, no execution.
// RULE2: power reset release gives full por reset, then execution starts.
// RULE3: soft reset pin low holds the device in software reset.
// RULE4: soft reset release resets core, digital registers and peripherals.
// RULE5: soft reset spares por-only registers, rtc, debug engine, scan debugger.
// RULE6: once soft reset pin is sensed low, device drives it low.
// RULE7: drive lasts exactly six system clock cycles, then the pin is released.
// RULE8: after each drive, sense again and repeat until pin reads high.
// RULE9: both reset inputs pass two synchronising flip-flops before use.
`timescale 1ns/100ps

module reset_pin_controller #(
  parameter int unsigned DRIVE_CYCLES = reset_pin_pkg::DRIVE_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic power_reset_in_n,
  input wire logic soft_reset_io_n_in,
  output logic soft_reset_io_n_out,
  output logic soft_reset_io_n_oe,
  output logic por_reset_req,
  output logic core_reset_req,
  output logic run_enable
);

  localparam int unsigned CW = reset_pin_pkg::DRIVE_CNT_W;
  localparam logic [CW-1:0] DRIVE_LAST = CW'(DRIVE_CYCLES - 1);

  if (DRIVE_CYCLES < 1 || DRIVE_CYCLES > (1 << CW)) begin : g_bad_drive
    $error("drive count does not fit the counter");
  end

  logic pwr_n_s;
  logic soft_n_s;

  // RULE9: power input sync
  reset_sync #(
    .STAGES(reset_pin_pkg::SYNC_STAGES),
    .RESET_VAL(1'b0)
  ) u_sync_pwr (
    .clk(clk),
    .rst_b(rst_b),
    .din(power_reset_in_n),
    .dout(pwr_n_s)
  );

  // RULE9: soft pin sync; resets high, pin counts as released
  reset_sync #(
    .STAGES(reset_pin_pkg::SYNC_STAGES),
    .RESET_VAL(1'b1)
  ) u_sync_soft (
    .clk(clk),
    .rst_b(rst_b),
    .din(soft_reset_io_n_in),
    .dout(soft_n_s)
  );

  reset_pin_pkg::seq_state_t state_q, state_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [CW-1:0] blank_q, blank_d;
  reset_pin_pkg::reset_req_t req_q, req_d;
  reset_pin_pkg::pad_drive_t pad_q, pad_d;

  // own drive echoes through the sync chain; ignore it this long after release
  localparam logic [CW-1:0] BLANK_LAST = CW'(reset_pin_pkg::SYNC_STAGES);

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    blank_d = blank_q;
    pad_d = '{out_val: 1'b0, out_en: 1'b0};
    req_d = '{por_domain: 1'b0, core_domain: 1'b0, run_allowed: 1'b1};
    if (!pwr_n_s) begin
      // RULE1: hold everything in reset
      state_d = reset_pin_pkg::ST_POWER_HOLD;
      cnt_d = reset_pin_pkg::DRIVE_CNT_RST;
      blank_d = reset_pin_pkg::DRIVE_CNT_RST;
      req_d = '{por_domain: 1'b1, core_domain: 1'b1, run_allowed: 1'b0};
    end else begin
      case (state_q)
        reset_pin_pkg::ST_POWER_HOLD: begin
          // RULE2: por released, execution starts next cycle
          state_d = reset_pin_pkg::ST_RUN;
        end
        reset_pin_pkg::ST_RUN: begin
          // RULE6: sensed low, start driving
          if (!soft_n_s) begin
            state_d = reset_pin_pkg::ST_DRIVE;
            cnt_d = reset_pin_pkg::DRIVE_CNT_RST;
            pad_d = '{out_val: 1'b0, out_en: 1'b1};
            // RULE3: held in soft reset, por domain left alone
            req_d = '{por_domain: 1'b0, core_domain: 1'b1, run_allowed: 1'b0};
          end
        end
        reset_pin_pkg::ST_DRIVE: begin
          // RULE3: soft reset held while driving
          req_d = '{por_domain: 1'b0, core_domain: 1'b1, run_allowed: 1'b0};
          // RULE7: six cycles of drive
          if (cnt_q == DRIVE_LAST) begin
            state_d = reset_pin_pkg::ST_SENSE;
            blank_d = reset_pin_pkg::DRIVE_CNT_RST;
          end else begin
            cnt_d = cnt_q + CW'(1);
            pad_d = '{out_val: 1'b0, out_en: 1'b1};
          end
        end
        reset_pin_pkg::ST_SENSE: begin
          req_d = '{por_domain: 1'b0, core_domain: 1'b1, run_allowed: 1'b0};
          if (blank_q != BLANK_LAST) begin
            blank_d = blank_q + CW'(1);
          end else if (!soft_n_s) begin
            // RULE8: still low, drive again
            state_d = reset_pin_pkg::ST_DRIVE;
            cnt_d = reset_pin_pkg::DRIVE_CNT_RST;
            pad_d = '{out_val: 1'b0, out_en: 1'b1};
          end else begin
            // RULE4: released; core reset drops, execution resumes
            // RULE5: por_domain stays low, so spared logic keeps its state
            state_d = reset_pin_pkg::ST_RUN;
            req_d = '{por_domain: 1'b0, core_domain: 1'b0, run_allowed: 1'b1};
          end
        end
        default: begin
          state_d = reset_pin_pkg::ST_POWER_HOLD;
          req_d = '{por_domain: 1'b1, core_domain: 1'b1, run_allowed: 1'b0};
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= reset_pin_pkg::ST_POWER_HOLD;
      cnt_q <= reset_pin_pkg::DRIVE_CNT_RST;
      blank_q <= reset_pin_pkg::DRIVE_CNT_RST;
      req_q <= '{por_domain: 1'b1, core_domain: 1'b1, run_allowed: 1'b0};
      pad_q <= '{out_val: 1'b0, out_en: 1'b0};
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      blank_q <= blank_d;
      req_q <= req_d;
      pad_q <= pad_d;
    end
  end

  assign soft_reset_io_n_out = pad_q.out_val;
  assign soft_reset_io_n_oe = pad_q.out_en;
  assign por_reset_req = req_q.por_domain;
  assign core_reset_req = req_q.core_domain;
  assign run_enable = req_q.run_allowed;

  // helper: length of current drive burst
  logic [3:0] burst_q, burst_d;
  always_comb begin
    burst_d = soft_reset_io_n_oe ? burst_q + 4'h1 : 4'h0;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      burst_q <= 4'h0;
    end else begin
      burst_q <= burst_d;
    end
  end

  property p_hold_while_power;
    @(posedge clk) disable iff (!rst_b)
      !pwr_n_s |=> (por_reset_req && !run_enable);
  endproperty
  a_hold_while_power: assert property (p_hold_while_power) // RULE1
    else $error("run allowed while power reset held");

  property p_power_release;
    @(posedge clk) disable iff (!rst_b)
      (state_q == reset_pin_pkg::ST_POWER_HOLD && pwr_n_s) |=> !por_reset_req ##0 run_enable;
  endproperty
  a_power_release: assert property (p_power_release) // RULE2
    else $error("no start after power reset release");

  property p_soft_hold;
    @(posedge clk) disable iff (!rst_b)
      soft_reset_io_n_oe |-> (core_reset_req && !run_enable);
  endproperty
  a_soft_hold: assert property (p_soft_hold) // RULE3
    else $error("core not held while pin driven");

  property p_soft_release;
    @(posedge clk) disable iff (!rst_b)
      ($fell(core_reset_req) && !por_reset_req) |-> run_enable;
  endproperty
  a_soft_release: assert property (p_soft_release) // RULE4
    else $error("core release without execution");

  property p_soft_spares_por;
    @(posedge clk) disable iff (!rst_b)
      (pwr_n_s && $past(pwr_n_s) && !por_reset_req) |=> !por_reset_req;
  endproperty
  a_soft_spares_por: assert property (p_soft_spares_por) // RULE5
    else $error("por request raised without power reset");

  property p_drive_on_low;
    @(posedge clk) disable iff (!rst_b)
      (state_q == reset_pin_pkg::ST_RUN && pwr_n_s && !soft_n_s)
        |=> soft_reset_io_n_oe && !soft_reset_io_n_out;
  endproperty
  a_drive_on_low: assert property (p_drive_on_low) // RULE6
    else $error("low pin not driven low");

  property p_drive_six;
    @(posedge clk) disable iff (!rst_b)
      $rose(soft_reset_io_n_oe) && pwr_n_s |-> soft_reset_io_n_oe [*6] ##1 !soft_reset_io_n_oe;
  endproperty
  a_drive_six: assert property (p_drive_six) // RULE7
    else $error("drive burst not six cycles");

  property p_burst_bound;
    @(posedge clk) disable iff (!rst_b)
      burst_q <= 4'h6;
  endproperty
  a_burst_bound: assert property (p_burst_bound) // RULE7
    else $error("drive burst too long");

  property p_redrive;
    @(posedge clk) disable iff (!rst_b)
      (state_q == reset_pin_pkg::ST_SENSE && blank_q == BLANK_LAST && !soft_n_s && pwr_n_s)
        |=> soft_reset_io_n_oe;
  endproperty
  a_redrive: assert property (p_redrive) // RULE8
    else $error("pin still low but not driven again");

  property p_sync_delay;
    @(posedge clk) disable iff (!rst_b)
      $fell(pwr_n_s) |-> $past(power_reset_in_n, 2) == 1'b0;
  endproperty
  a_sync_delay: assert property (p_sync_delay) // RULE9
    else $error("power input not two flops late");

endmodule

/* File: ext_reset_model.sv */
/*
  far-side model: external supervisor on both reset pins.
  assumes pull-ups on both pins; device pad drives only low.
*/
`timescale 1ns/100ps

module ext_reset_model (
  input wire logic soft_hold,
  input wire logic power_hold,
  input wire logic dev_oe,
  input wire logic dev_out,
  output logic soft_pad,
  output logic power_pin
);
  // open drain: released pins float to the pull-up level
  assign soft_pad = ((dev_oe && !dev_out) || soft_hold) ? 1'b0 : 1'b1;
  assign power_pin = power_hold ? 1'b0 : 1'b1;
endmodule

/* File: tb.sv */
/*
  self-checking bench for the reset pin controller.
  assumes the supervisor model holds the soft pin for random lengths.
*/
`timescale 1ns/100ps

module tb;
  logic clk, rst_b, soft_hold, power_hold;
  logic pad, pwr, out_v, oe, por, core, run;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int run_len = 0;
  int bursts = 0;
  logic [15:0] seed = 16'h29fa;

  ext_reset_model model (.soft_hold(soft_hold), .power_hold(power_hold), .dev_oe(oe),
    .dev_out(out_v), .soft_pad(pad), .power_pin(pwr));

  reset_pin_controller DUT (.clk(clk), .rst_b(rst_b), .power_reset_in_n(pwr),
    .soft_reset_io_n_in(pad), .soft_reset_io_n_out(out_v), .soft_reset_io_n_oe(oe),
    .por_reset_req(por), .core_reset_req(core), .run_enable(run));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // bursts for a hold of len cycles: one per drive-and-sense round
  function automatic int min_bursts(input int len);
    int round;
    int first;
    round = int'(reset_pin_pkg::DRIVE_CYCLES + reset_pin_pkg::SYNC_STAGES) + 1;
    first = round + 1;
    return (len < first) ? 1 : 2 + (len - first) / round;
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      wrap_up();
    end
  end

  // burst monitor on the pad drive; negedge keeps clear of the launch edge
  always @(negedge clk) begin
    if (rst_b === 1'b1 && oe === 1'b1) begin
      run_len++;
      check({7'h0, out_v}, 8'h00);
    end else if (run_len != 0) begin
      check(run_len[7:0], 8'(reset_pin_pkg::DRIVE_CYCLES));
      bursts++;
      run_len = 0;
    end
  end

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check_state(input logic p, input logic c, input logic r);
    check({7'h0, por}, {7'h0, p});
    check({7'h0, core}, {7'h0, c});
    check({7'h0, run}, {7'h0, r});
  endtask

  initial begin
    int len;
    int i;
    rst_b = 1'b0;
    soft_hold = 1'b0;
    power_hold = 1'b0;
    settle(20);
    rst_b = 1'b1;
    settle(6);
    check_state(1'b0, 1'b0, 1'b1);
    // soft activity must be ignored while power reset held
    power_hold = 1'b1;
    soft_hold = 1'b1;
    settle(5);
    check_state(1'b1, 1'b1, 1'b0);
    check({7'h0, oe}, 8'h00);
    soft_hold = 1'b0;
    power_hold = 1'b0;
    settle(6);
    check_state(1'b0, 1'b0, 1'b1);
    for (int k = 0; k < 14; k++) begin
      seed = lfsr(seed);
      len = (k == 0) ? 1 : (k == 1) ? 40 : int'(seed % 16'h0028) + 1;
      bursts = 0;
      soft_hold = 1'b1;
      for (i = 1; i <= ((len > 5) ? len : 5); i++) begin
        settle(1);
        if (i == 2) begin
          check({7'h0, oe}, 8'h00);
        end
        if (i == 5) begin
          check_state(1'b0, 1'b1, 1'b0);
        end
        if (i == len) begin
          soft_hold = 1'b0;
        end
      end
      i = 0;
      while (run !== 1'b1 && i < 200) begin
        settle(1);
        i++;
      end
      check_state(1'b0, 1'b0, 1'b1);
      check(8'(bursts), 8'(min_bursts(len)));
      settle(int'(seed[2:0]) + 1);
    end
    wrap_up();
  end
endmodule
